// file: core/spl_cfg.sv
// power-down, counter reset, lock detect and resync configuration register bank
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`include "spl_regs.svh"
`default_nettype none
module spl_cfg
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        compare_tick,
    input  wire logic        lock_seen,
    output logic             blocks_enabled,
    output logic             regulator_on,
    output logic             cp_tristate,
    output logic             counters_in_reset,
    output logic             resync_enable,
    output logic [1:0]       lock_bias,
    output logic [11:0]      second_resync_divider,
    output logic             lock_declared,
    output logic             load_lost
);
    spl_pkg::spl_ctrl_t ctrl;
    spl_pkg::spl_state_t st_q;
    spl_pkg::spl_state_t st_d;

    logic [31:0] word_q;
    logic [31:0] r6_q;
    logic [31:0] r7_q;
    logic [31:0] r8_q;
    logic [31:0] r9_q;
    logic [31:0] r10_q;
    logic [31:0] r11_q;
    logic [31:0] r12_q;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic        rd_pend_q;
    logic [11:0] rd_addr_q;
    logic        load_strobe;
    logic [6:0]  ld_cnt_q;
    logic        lock_q;
    logic        lost_q;
    logic        check_tick;
    logic        stuck_q;
    logic [31:0] rd_mux;

    // bus slave: always zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            rd_addr_q <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend_q <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            rd_pend_q <= hsel && htrans[1] && !hwrite;
            wr_addr_q <= haddr[11:0];
            rd_addr_q <= haddr[11:0];
        end
    end

    // staging word the host writes in one bus write; a ctrl write with bit 0 set pulses the load strobe
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            word_q <= `SPL_RESET_WORD;
        else if (wr_pend_q && wr_addr_q == `SPL_OFF_WORD_DATA)
            word_q <= hwdata;
    end

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            spl_pkg::SPL_IDLE:
                if (wr_pend_q && wr_addr_q == `SPL_OFF_WORD_CTRL && hwdata[0])
                    st_d = spl_pkg::SPL_LOAD;
            spl_pkg::SPL_LOAD:
                st_d = spl_pkg::SPL_DONE;
            spl_pkg::SPL_DONE:
                st_d = spl_pkg::SPL_IDLE;
            default:
                st_d = spl_pkg::SPL_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= spl_pkg::SPL_IDLE;
        else
            st_q <= st_d;
    end

    assign load_strobe = (st_q == spl_pkg::SPL_LOAD);

    // only the addressed word takes the upper 28 bits; select code is kept too
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r6_q  <= `SPL_RESET_WORD;
            r7_q  <= `SPL_RESET_WORD;
            r8_q  <= `SPL_RESET_WORD;
            r9_q  <= `SPL_RESET_WORD;
            r10_q <= `SPL_RESET_WORD;
            r11_q <= `SPL_RESET_WORD;
            r12_q <= `SPL_RESET_WORD;
        end
        else if (load_strobe && !stuck_q)
        begin
            unique case (word_q[3:0])
                `SPL_SEL_R6:  r6_q  <= word_q;
                `SPL_SEL_R7:  r7_q  <= word_q;
                `SPL_SEL_R8:  r8_q  <= word_q;
                `SPL_SEL_R9:  r9_q  <= word_q;
                `SPL_SEL_R10: r10_q <= word_q;
                `SPL_SEL_R11: r11_q <= word_q;
                `SPL_SEL_R12: r12_q <= word_q;
                default:      ;
            endcase
        end
    end

    // writing power-down while synchronised load is on locks the chip out of wake-up
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stuck_q <= 1'b0;
        else if (load_strobe && word_q[3:0] == `SPL_SEL_R6 && word_q[`SPL_R6_PWRDN_BIT] && r12_q[`SPL_R12_LESYNC_BIT])
            stuck_q <= 1'b1;
    end

    always_comb
    begin
        ctrl.pwrdn                     = r6_q[`SPL_R6_PWRDN_BIT] || stuck_q;
        ctrl.cp_tristate               = r6_q[`SPL_R6_CP3S_BIT];
        ctrl.counter_reset             = r6_q[`SPL_R6_CNTRST_BIT];
        ctrl.regulator_on              = !ctrl.pwrdn || r11_q[`SPL_R11_PDS_BIT];
        ctrl.lock_detect_initial_count = r7_q[`SPL_R7_LDCNT_HI:`SPL_R7_LDCNT_LO];
        ctrl.lock_check_rate_select    = r7_q[`SPL_R7_RATE_BIT];
        ctrl.clk_div_mode              = r7_q[`SPL_R7_MODE_HI:`SPL_R7_MODE_LO];
        ctrl.second_resync_divider     = r7_q[`SPL_R7_SECOND_RESYNC_DIVIDER_HI:`SPL_R7_SECOND_RESYNC_DIVIDER_LO];
        ctrl.lock_bias                 = r9_q[`SPL_R9_BIAS_HI:`SPL_R9_BIAS_LO];
        ctrl.resync_enable             = (ctrl.clk_div_mode == `SPL_MODE_RESYNC);
    end

    // power-down gates outputs only; stored words untouched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            blocks_enabled        <= 1'b1;
            regulator_on          <= 1'b1;
            cp_tristate           <= 1'b0;
            counters_in_reset     <= 1'b0;
            resync_enable         <= 1'b0;
            lock_bias             <= 2'h0;
            second_resync_divider <= 12'h000;
        end
        else
        begin
            blocks_enabled        <= !ctrl.pwrdn;
            regulator_on          <= ctrl.regulator_on;
            cp_tristate           <= ctrl.cp_tristate || ctrl.pwrdn;
            counters_in_reset     <= ctrl.counter_reset || ctrl.pwrdn;
            resync_enable         <= ctrl.resync_enable && !ctrl.pwrdn;
            lock_bias             <= ctrl.lock_bias;
            second_resync_divider <= ctrl.second_resync_divider;
        end
    end

    spl_check_tick u_tick
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .compare_tick (compare_tick),
        .every_cycle  (ctrl.lock_check_rate_select),
        .hold         (ctrl.counter_reset || ctrl.pwrdn),
        .check_tick   (check_tick)
    );

    // lock counter: reloaded on a miss, lock on a hit that finds it at zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ld_cnt_q <= 7'h00;
            lock_q   <= 1'b0;
        end
        else if (ctrl.counter_reset || ctrl.pwrdn || (check_tick && !lock_seen))
        begin
            ld_cnt_q <= ctrl.lock_detect_initial_count;
            lock_q   <= 1'b0;
        end
        else if (check_tick)
        begin
            if (ld_cnt_q == 7'h00)
                lock_q <= 1'b1;
            else
                ld_cnt_q <= ld_cnt_q - 7'h01;
        end
    end

    assign lock_declared = lock_q;
    assign load_lost     = lost_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lost_q <= 1'b0;
        else
            lost_q <= stuck_q;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (rd_addr_q)
            `SPL_OFF_WORD_DATA: rd_mux = word_q;
            `SPL_OFF_REG6:      rd_mux = r6_q;
            `SPL_OFF_REG7:      rd_mux = r7_q;
            `SPL_OFF_REG8:      rd_mux = r8_q;
            `SPL_OFF_REG9:      rd_mux = r9_q;
            `SPL_OFF_REG10:     rd_mux = r10_q;
            `SPL_OFF_REG11:     rd_mux = r11_q;
            `SPL_OFF_REG12:     rd_mux = r12_q;
            `SPL_OFF_STATUS:    rd_mux = {28'h0000000, stuck_q, lock_q, ctrl.resync_enable, !ctrl.pwrdn};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // data phase of a zero-wait read is combinational from the captured address
    always_comb
    begin
        hrdata = rd_pend_q ? rd_mux : 32'h0000_0000;
    end

    // control outputs follow the stored words one edge later
    a_pwrdn_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl.pwrdn |=> !blocks_enabled && cp_tristate && counters_in_reset)
        else $error("power-down did not disable blocks");
    a_pwrdn_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl.pwrdn |=> blocks_enabled)
        else $error("blocks stayed disabled after wake-up");
    a_regs_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl.pwrdn && !load_strobe) |=> $stable(r7_q) && $stable(r9_q))
        else $error("stored word changed in power-down");
    a_words_held: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl.pwrdn && !load_strobe) |=> $stable(r6_q) && $stable(r11_q) && $stable(r12_q))
        else $error("control word changed in power-down");
    a_reg_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl.pwrdn && r11_q[31]) |=> regulator_on)
        else $error("regulator dropped with select bit set");
    a_reg_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl.pwrdn && !r11_q[`SPL_R11_PDS_BIT]) |=> !regulator_on)
        else $error("regulator left on without select bit");
    a_reg_awake: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl.pwrdn |=> regulator_on)
        else $error("regulator off while running");
    a_stuck_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        stuck_q |=> stuck_q && !blocks_enabled)
        else $error("woke up despite synchronised-load lockout");
    a_stuck_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
        stuck_q |=> $stable(r6_q) && $stable(r7_q) && $stable(r12_q))
        else $error("load accepted during lockout");
    a_cp_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
        r6_q[5] |=> cp_tristate)
        else $error("charge pump not three-stated");
    a_cp_normal: assert property (@(posedge hclk) disable iff (!hresetn)
        (!r6_q[`SPL_R6_CP3S_BIT] && !ctrl.pwrdn) |=> !cp_tristate)
        else $error("charge pump three-stated without cause");
    a_cnt_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (r6_q[4] && !ctrl.pwrdn) |=> counters_in_reset && !lock_q)
        else $error("counters not held in reset");
    a_cnt_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (!r6_q[`SPL_R6_CNTRST_BIT] && !ctrl.pwrdn) |=> !counters_in_reset)
        else $error("counters held in reset without cause");
    a_resync_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        (r7_q[19:18] != 2'h2) |=> !resync_enable)
        else $error("resync enabled outside mode 10");
    a_resync_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (r7_q[`SPL_R7_MODE_HI:`SPL_R7_MODE_LO] == `SPL_MODE_RESYNC && !ctrl.pwrdn) |=> resync_enable)
        else $error("resync not enabled in mode 10");
    a_second_resync_divider_field: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 second_resync_divider == $past(r7_q[17:6]) && lock_bias == $past(r9_q[31:30]))
        else $error("field output mismatch");

    // lock counter and word select
    a_ld_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        (check_tick && !lock_seen && !ctrl.counter_reset) |=> ld_cnt_q == $past(ctrl.lock_detect_initial_count))
        else $error("lock counter not reloaded");
    a_lock_detect_initial_count_down: assert property (@(posedge hclk) disable iff (!hresetn)
        (check_tick && lock_seen && ld_cnt_q != 7'h00) |=> ld_cnt_q == $past(ld_cnt_q) - 7'h01)
        else $error("lock counter did not count down");
    a_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (check_tick && lock_seen && ld_cnt_q == 7'h00) |=> lock_q)
        else $error("lock not declared at zero count");
    a_fast_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (compare_tick && ctrl.lock_check_rate_select && !ctrl.counter_reset && !ctrl.pwrdn) |-> check_tick)
        else $error("fast rate skipped a comparison");
    a_slow_skip: assert property (@(posedge hclk) disable iff (!hresetn)
        (check_tick && !ctrl.lock_check_rate_select) |=> !check_tick || ctrl.lock_check_rate_select)
        else $error("slow rate checked two comparisons in a row");
    a_select_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (load_strobe && !stuck_q && word_q[3:0] == 4'h7) |=> $stable(r9_q) && r7_q == $past(word_q))
        else $error("word stored into wrong register");
    a_select_r9: assert property (@(posedge hclk) disable iff (!hresetn)
        (load_strobe && !stuck_q && word_q[3:0] == `SPL_SEL_R9) |=> $stable(r7_q) && r9_q == $past(word_q))
        else $error("word nine not stored alone");
    a_bad_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (load_strobe && (word_q[3:0] < 4'h6 || word_q[3:0] > 4'hC)) |=> $stable(r6_q) && $stable(r7_q) && $stable(r9_q))
        else $error("word with unknown select code was stored");
endmodule
`default_nettype wire

// file: core/spl_check_tick.sv
// lock check tick divider: every comparison or every 32nd
`include "spl_regs.svh"
`default_nettype none
module spl_check_tick
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic compare_tick,
    input  wire logic every_cycle,
    input  wire logic hold,
    output logic      check_tick
);
    logic [5:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 6'h00;
        else if (hold)
            cnt_q <= 6'h00;
        else if (compare_tick)
            cnt_q <= (cnt_q == `SPL_SLOW_CHECK_DIV - 6'h01) ? 6'h00 : cnt_q + 6'h01;
    end

    always_comb
    begin
        check_tick = compare_tick && !hold && (every_cycle || cnt_q == `SPL_SLOW_CHECK_DIV - 6'h01);
    end

    a_slow_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (check_tick && !every_cycle) |-> (cnt_q == 6'h1F))
        else $error("slow check tick off the 32nd comparison");
endmodule
`default_nettype wire

// file: core/spl_pkg.sv
// types shared by the power/lock/resync config block
`default_nettype none
package spl_pkg;
    typedef struct packed {
        logic        pwrdn;
        logic        cp_tristate;
        logic        counter_reset;
        logic        regulator_on;
        logic [6:0]  lock_detect_initial_count;
        logic        lock_check_rate_select;
        logic [1:0]  clk_div_mode;
        logic [11:0] second_resync_divider;
        logic [1:0]  lock_bias;
        logic        resync_enable;
    } spl_ctrl_t;

    typedef enum logic [2:0] {
        SPL_IDLE  = 3'b001,
        SPL_LOAD  = 3'b010,
        SPL_DONE  = 3'b100
    } spl_state_t;
endpackage
`default_nettype wire

// file: core/spl_pkg_end.sv
// intentionally minimal: package compile-order anchor is spl_pkg.sv
`default_nettype none
`default_nettype wire

// file: core/spl_regs.svh
// register offsets, field positions, reset values and counts for the power/lock/resync config block
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

`define SPL_OFF_WORD_DATA      12'h000
`define SPL_OFF_WORD_CTRL      12'h004
`define SPL_OFF_REG6           12'h008
`define SPL_OFF_REG7           12'h00C
`define SPL_OFF_REG8           12'h010
`define SPL_OFF_REG9           12'h014
`define SPL_OFF_REG10          12'h018
`define SPL_OFF_REG11          12'h01C
`define SPL_OFF_REG12          12'h020
`define SPL_OFF_STATUS         12'h024

`define SPL_SEL_R6             4'h6
`define SPL_SEL_R7             4'h7
`define SPL_SEL_R8             4'h8
`define SPL_SEL_R9             4'h9
`define SPL_SEL_R10            4'hA
`define SPL_SEL_R11            4'hB
`define SPL_SEL_R12            4'hC

`define SPL_R6_PWRDN_BIT       6
`define SPL_R6_CP3S_BIT        5
`define SPL_R6_CNTRST_BIT      4
`define SPL_R7_LDCNT_HI        31
`define SPL_R7_LDCNT_LO        25
`define SPL_R7_RATE_BIT        24
`define SPL_R7_NDLY_HI         23
`define SPL_R7_NDLY_LO         22
`define SPL_R7_PSB_HI          21
`define SPL_R7_PSB_LO          20
`define SPL_R7_MODE_HI         19
`define SPL_R7_MODE_LO         18
`define SPL_R7_SECOND_RESYNC_DIVIDER_HI         17
`define SPL_R7_SECOND_RESYNC_DIVIDER_LO         6
`define SPL_R9_BIAS_HI         31
`define SPL_R9_BIAS_LO         30
`define SPL_R11_PDS_BIT        31
`define SPL_R12_LESYNC_BIT     20

`define SPL_RESET_WORD         32'h0000_0000
`define SPL_MODE_RESYNC        2'h2
`define SPL_MODE_OFF           2'h0
`define SPL_SLOW_CHECK_DIV     6'h20
`define SPL_LDCNT_W            7
`define SPL_NDLY_VAL           2'h1
`define SPL_PSB_VAL            2'h2

`endif

// file: tb/spl_host.sv
// host model: single AHB-Lite master that stages and loads config words
`include "spl_regs.svh"
`default_nettype none
module spl_host
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             hang
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hang = 1'b0;
    end

    // the bound only guards a hang; the slave decides its own latency
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge hclk);
        end
        if (n == 16)
            hang <= 1'b1;
    endtask

    // call right after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        wait_ready();
        q = hrdata;
    endtask

    task automatic load(inout logic [31:0] w);
        logic [31:0] q;
        if (w[3:0] == 4'h7)
        begin
            w[`SPL_R7_NDLY_HI:`SPL_R7_NDLY_LO] = `SPL_NDLY_VAL;
            w[`SPL_R7_PSB_HI:`SPL_R7_PSB_LO] = `SPL_PSB_VAL;
        end
        if (w[3:0] == 4'h8 || w[3:0] == 4'hA)
            w[31:4] = 28'h0;
        if (w[3:0] == 4'h9)
            w[29:4] = 26'h0;
        xfer(1'b1, `SPL_OFF_WORD_DATA, w, q);
        xfer(1'b1, `SPL_OFF_WORD_CTRL, 32'h1, q);
        // staged word lands on the next edge, outputs one edge after that
        repeat (3) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the power/lock/resync config bank
`include "spl_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        compare_tick = 1'b0;
    logic        lock_seen = 1'b0;
    logic        hsel, hwrite, hang, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, lock_bias;
    logic [2:0]  hsize;
    logic        blocks_enabled, regulator_on, cp_tristate, counters_in_reset;
    logic        resync_enable, lock_declared, load_lost;
    logic [11:0] second_resync_divider;
    logic [31:0] m [0:15];
    logic        stuck;
    int          num_errors = 0;
    int          n_tests = 0;
    int          seed = 32'hd787ab49;

    always #12.5 hclk = ~hclk;

    spl_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));

    spl_cfg u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .compare_tick(compare_tick), .lock_seen(lock_seen),
        .blocks_enabled(blocks_enabled), .regulator_on(regulator_on), .cp_tristate(cp_tristate),
        .counters_in_reset(counters_in_reset), .resync_enable(resync_enable), .lock_bias(lock_bias),
        .second_resync_divider(second_resync_divider), .lock_declared(lock_declared),
        .load_lost(load_lost));

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] img(input int s);
        return 32'(`SPL_OFF_REG6) + 32'(4 * (s - 6));
    endfunction

    // expected control outputs from the stored words and the lockout flag
    function automatic logic [5:0] exp_outs();
        logic pd;
        pd = m[6][6] | stuck;
        return {~pd, ~(pd & ~m[11][31]), m[6][5] | pd, m[6][4] | pd, (m[7][19:18] == 2'h2) & ~pd, stuck};
    endfunction

    task automatic chk_all();
        check({26'h0, blocks_enabled, regulator_on, cp_tristate, counters_in_reset, resync_enable,
            load_lost}, {26'h0, exp_outs()});
        check({30'h0, lock_bias}, {30'h0, m[9][31:30]});
        check({30'h0, hreadyout, hresp}, 32'h0000_0002);
        check({20'h0, second_resync_divider}, {20'h0, m[7][17:6]});
    endtask

    task automatic chk_img();
        logic [31:0] q;
        for (int s = 6; s <= 12; s++)
        begin
            u_host.xfer(1'b0, img(s), 32'h0, q);
            check(q, m[s]);
        end
    endtask

    task automatic put(input logic [31:0] w);
        int s;
        s = int'(w[3:0]);
        u_host.load(w);
        if (!stuck && s >= 6 && s <= 12)
            m[s] = w;
        if (s == 6 && w[6] && m[12][20])
            stuck = 1'b1;
        chk_all();
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge hclk);
            compare_tick <= 1'b1;
            @(posedge hclk);
            compare_tick <= 1'b0;
        end
        repeat (3) @(posedge hclk);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int s = 0; s < 16; s++)
            m[s] = 32'h0;
        stuck = 1'b0;
        chk_all();
        chk_img();
    endtask

    always @(posedge hclk)
        if (hang === 1'b1)
        begin
            num_errors++;
            summarize();
        end

    initial
    begin
        #(25 * 60000);
        num_errors++;
        summarize();
    end

    initial
    begin
        logic [31:0] w;
        do_reset();
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            w = $random(seed);
            w[3:0] = 4'h7;
            w[19:18] = i[0] ? `SPL_MODE_RESYNC : `SPL_MODE_OFF;
            put(w);
            put({2'(i), 26'h0, 4'h9});
        end
        put(32'hFFFF_FFF3);
        chk_img();
        $display("test random config done");
        put(32'h0000_0026);
        put(32'h0000_0016);
        put(32'h8000_000B);
        put(32'h0000_000C);
        put(32'h0000_0046);
        chk_img();
        put(32'h0000_000B);
        put(32'h8000_000B);
        put(32'h0000_0006);
        $display("test power-down done");
        put({7'd1, 1'b1, 2'h1, 2'h2, 20'h00007});
        ticks(2);
        lock_seen <= 1'b1;
        ticks(1);
        check({31'h0, lock_declared}, 32'h0);
        ticks(1);
        check({31'h0, lock_declared}, 32'h1);
        put({7'd1, 1'b0, 2'h1, 2'h2, 20'h00007});
        lock_seen <= 1'b0;
        ticks(33);
        check({31'h0, lock_declared}, 32'h0);
        lock_seen <= 1'b1;
        // at most one slow check fits in eight ticks, two hits are needed
        ticks(8);
        check({31'h0, lock_declared}, 32'h0);
        ticks(64);
        check({31'h0, lock_declared}, 32'h1);
        $display("test lock detect done");
        put(32'h0010_000C);
        put(32'h0000_0046);
        put(32'h0000_0006);
        chk_img();
        do_reset();
        $display("test lockout done");
        summarize();
    end
endmodule
`default_nettype wire
